//--- hw/adc_ctrl_pkg.sv
// Package for the converter control selection block.
// Holds register offsets, field positions, reset values and frame layout.
// Assumes a single serial master and a 16-bit register word.
package adc_ctrl_pkg;

    // Register word index of each serial-accessible register.
    localparam logic [3:0] MAIN_CONTROL_ADDR         = 4'h0;
    localparam logic [3:0] FIRST_CHANNEL_FS_ADDR     = 4'h3;
    localparam logic [3:0] SECOND_CHANNEL_FS_ADDR    = 4'hb;

    // Bit positions inside the main control register.
    localparam int OUTPUT_PHASE_BIT_POS              = 14;
    localparam int TEST_PATTERN_BIT_POS              = 12;
    localparam int FIRST_CHANNEL_POWERDOWN_BIT_POS   = 11;
    localparam int SECOND_CHANNEL_POWERDOWN_BIT_POS  = 10;

    // Register width and reset values.
    localparam int REG_WIDTH                         = 16;
    localparam logic [15:0] MAIN_CONTROL_RESET       = 16'h0000;
    localparam logic [15:0] FULL_SCALE_MIN           = 16'h0000;
    localparam logic [15:0] FULL_SCALE_MID           = 16'h8000;
    localparam logic [15:0] FULL_SCALE_RESET         = 16'h8000;

    // Serial frame layout: 8 header bits then 16 data bits, MSB first.
    localparam logic [4:0] HEADER_BITS               = 5'h08;
    localparam logic [4:0] FRAME_BITS                = 5'h18;
    localparam int HEADER_READ_POS                   = 7;

    // Power-up delay of a channel in sampling clock cycles.
    localparam int POWERUP_CYCLES                    = 16;

endpackage

//--- hw/serial_config_port.sv
// Serial shift engine of the configuration port, clocked by the serial clock.
// Assumes register read data is quasi-static: it only changes through this
// port's own writes or while the port is held disabled.
`timescale 1ns/10ps
module serial_config_port (
    input  wire logic        sclk_i,
    input  wire logic        serial_chip_select_n_i,
    input  wire logic        extended_control_enable_n_i,
    input  wire logic        sdi_i,
    input  wire logic [15:0] main_control_i,
    input  wire logic [15:0] first_fs_i,
    input  wire logic [15:0] second_fs_i,
    output logic             wr_toggle_o,
    output logic [3:0]       wr_addr_o,
    output logic [15:0]      wr_data_o,
    output logic             sdo_o,
    output logic             sdo_oe_o
);

    logic        frame_rst;
    logic [4:0]  cnt_reg;
    logic [4:0]  cnt_next;
    logic [7:0]  hdr_reg;
    logic [7:0]  hdr_next;
    logic [15:0] din_reg;
    logic [15:0] din_next;
    logic [15:0] rword_reg;
    logic [15:0] rword_next;
    logic        tog_reg;
    logic        tog_next;
    logic [3:0]  waddr_reg;
    logic [3:0]  waddr_next;
    logic [15:0] wdata_reg;
    logic [15:0] wdata_next;
    logic        sdo_reg;
    logic        sdo_next;
    logic        oe_reg;
    logic        oe_next;
    logic [3:0]  raddr;
    logic [4:0]  rbit;

    // Any frame ends when chip select rises or the port is disabled.
    assign frame_rst = serial_chip_select_n_i | extended_control_enable_n_i; // RQ13 RQ15

    assign raddr = {hdr_reg[2:0], sdi_i};
    assign rbit  = 5'd23 - cnt_reg;

    // Rising-edge shift of header and data; the read word loads at header end.
    always_comb begin
        cnt_next   = cnt_reg;
        hdr_next   = hdr_reg;
        din_next   = din_reg;
        rword_next = rword_reg;
        tog_next   = tog_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        if (cnt_reg < adc_ctrl_pkg::FRAME_BITS) begin
            cnt_next = cnt_reg + 5'd1;
        end
        if (cnt_reg < adc_ctrl_pkg::HEADER_BITS) begin
            hdr_next = {hdr_reg[6:0], sdi_i}; // RQ17
        end else if (cnt_reg < adc_ctrl_pkg::FRAME_BITS) begin
            din_next = {din_reg[14:0], sdi_i}; // RQ17
        end
        if (cnt_reg == adc_ctrl_pkg::HEADER_BITS - 5'd1) begin
            case (raddr)
                adc_ctrl_pkg::MAIN_CONTROL_ADDR:      rword_next = main_control_i;
                adc_ctrl_pkg::FIRST_CHANNEL_FS_ADDR:  rword_next = first_fs_i;
                adc_ctrl_pkg::SECOND_CHANNEL_FS_ADDR: rword_next = second_fs_i;
                default:                              rword_next = 16'h0000;
            endcase
        end
        if (cnt_reg == adc_ctrl_pkg::FRAME_BITS - 5'd1 &&
            !hdr_reg[adc_ctrl_pkg::HEADER_READ_POS]) begin
            waddr_next = hdr_reg[3:0];
            wdata_next = {din_reg[14:0], sdi_i};
            tog_next   = ~tog_reg;
        end
    end

    // Frame state clears at the end of every frame; the clock may stop freely.
    always_ff @(posedge sclk_i or posedge frame_rst) begin
        if (frame_rst) begin
            cnt_reg   <= 5'h00; // RQ14
            hdr_reg   <= 8'h00;
            din_reg   <= 16'h0000;
            rword_reg <= 16'h0000;
        end else begin
            cnt_reg   <= cnt_next; // RQ15
            hdr_reg   <= hdr_next;
            din_reg   <= din_next;
            rword_reg <= rword_next;
        end
    end

    // Completed write word and its event toggle survive chip select.
    always_ff @(posedge sclk_i or posedge extended_control_enable_n_i) begin
        if (extended_control_enable_n_i) begin
            tog_reg   <= 1'b0;
            waddr_reg <= 4'h0;
            wdata_reg <= 16'h0000;
        end else begin
            tog_reg   <= tog_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
        end
    end

    // Falling-edge output of read data, MSB first, during the data phase.
    always_comb begin
        sdo_next = sdo_reg;
        oe_next  = 1'b0;
        if (hdr_reg[adc_ctrl_pkg::HEADER_READ_POS] &&
            cnt_reg >= adc_ctrl_pkg::HEADER_BITS) begin
            oe_next = 1'b1;
            if (cnt_reg < adc_ctrl_pkg::FRAME_BITS) begin
                sdo_next = rword_reg[rbit[3:0]]; // RQ17
            end
        end
    end

    // Output driver is released whenever the frame ends.
    always_ff @(negedge sclk_i or posedge frame_rst) begin
        if (frame_rst) begin
            sdo_reg <= 1'b0;
            oe_reg  <= 1'b0; // RQ13
        end else begin
            sdo_reg <= sdo_next;
            oe_reg  <= oe_next;
        end
    end

    assign wr_toggle_o = tog_reg;
    assign wr_addr_o   = waddr_reg;
    assign wr_data_o   = wdata_reg;
    assign sdo_o       = sdo_reg;
    assign sdo_oe_o    = oe_reg;

endmodule

//--- hw/adc_control_pin_register_select.sv
// Control source selection of a dual-channel converter with its serial port.
// Assumes control pins are asynchronous to clk_i and the serial clock is a
// separate domain that may stop between frames.
//
// Functional notes
// RQ1 - Power-down pin high stops its channel
// RQ2 - Extended mode ORs power-down pins with bits 11/10
// RQ3 - Test-pattern pin drives pattern in pin mode
// RQ4 - Extended mode: test pattern from bit 12 only
// RQ5 - Demux pin high 1:1, low 1:2, always
// RQ6 - Range pin sets both channels in pin mode
// RQ7 - Extended mode: ranges from registers 3h, Bh
// RQ8 - Phase pin low 0 degrees, high 90
// RQ9 - Phase matters only in 1:2 demux
// RQ10 - Extended mode: phase from bit 14, default 0
// RQ11 - Enable low selects serial register control
// RQ12 - Enable high resets registers, uses pins
// RQ13 - Chip select gates shifting and output drive
// RQ14 - Serial clock may stop between accesses
// RQ15 - Shifting only happens in extended mode
// RQ16 - Power-up delay counted, channel not ready meanwhile
// RQ17 - Sample input on rise, update output on fall
`timescale 1ns/10ps
module adc_control_pin_register_select #(
    parameter int POWERUP_CYCLES = adc_ctrl_pkg::POWERUP_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        sclk_i,
    input  wire logic        first_channel_powerdown_i,
    input  wire logic        second_channel_powerdown_i,
    input  wire logic        test_pattern_select_i,
    input  wire logic        demux_ratio_select_i,
    input  wire logic        input_range_select_i,
    input  wire logic        output_phase_select_i,
    input  wire logic        extended_control_enable_n_i,
    input  wire logic        serial_chip_select_n_i,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    output logic             sdo_oe_o,
    output logic             extended_control_mode_o,
    output logic             first_channel_off_o,
    output logic             second_channel_off_o,
    output logic             first_channel_ready_o,
    output logic             second_channel_ready_o,
    output logic             test_pattern_o,
    output logic             non_demuxed_o,
    output logic             phase_90_o,
    output logic [15:0]      first_full_scale_o,
    output logic [15:0]      second_full_scale_o
);

    localparam int NPINS = 7;
    localparam int CW    = $clog2(POWERUP_CYCLES + 1);
    localparam logic [CW-1:0] PU_LOAD = CW'(POWERUP_CYCLES);

    logic [NPINS-1:0] pins_raw;
    logic [NPINS-1:0] pin_s1_reg;
    logic [NPINS-1:0] pin_s2_reg;
    logic             pd1_pin;
    logic             pd2_pin;
    logic             tpm_pin;
    logic             ndm_pin;
    logic             fsr_pin;
    logic             ph_pin;
    logic             extended_control_mode;

    logic             wr_toggle;
    logic [3:0]       wr_addr;
    logic [15:0]      wr_data;
    logic             tog_s1_reg;
    logic             tog_s2_reg;
    logic             tog_s3_reg;
    logic             wr_event;

    logic [15:0]      main_control_reg;
    logic [15:0]      main_control_next;
    logic [15:0]      first_channel_full_scale_reg;
    logic [15:0]      first_channel_full_scale_next;
    logic [15:0]      second_channel_full_scale_reg;
    logic [15:0]      second_channel_full_scale_next;

    logic             mode_reg;
    logic             off1_reg;
    logic             off2_reg;
    logic             tp_reg;
    logic             ndm_reg;
    logic             ph90_reg;
    logic [15:0]      fs1_reg;
    logic [15:0]      fs2_reg;
    logic             mode_next;
    logic             off1_next;
    logic             off2_next;
    logic             tp_next;
    logic             ndm_next;
    logic             ph90_next;
    logic [15:0]      fs1_next;
    logic [15:0]      fs2_next;
    logic             phase_sel;
    logic [1:0]       off_vec;
    logic [1:0]       ready_vec;

    // Every control pin is asynchronous, so each passes two flip-flops.
    assign pins_raw = {extended_control_enable_n_i, output_phase_select_i,
                       input_range_select_i, demux_ratio_select_i,
                       test_pattern_select_i, second_channel_powerdown_i,
                       first_channel_powerdown_i};

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_s1_reg <= 7'h40;
            pin_s2_reg <= 7'h40;
        end else begin
            pin_s1_reg <= pins_raw;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    assign pd1_pin = pin_s2_reg[0];
    assign pd2_pin = pin_s2_reg[1];
    assign tpm_pin = pin_s2_reg[2];
    assign ndm_pin = pin_s2_reg[3];
    assign fsr_pin = pin_s2_reg[4];
    assign ph_pin  = pin_s2_reg[5];
    assign extended_control_mode     = ~pin_s2_reg[6]; // RQ11

    // Serial shift engine on the serial clock; it resets itself when disabled.
    serial_config_port u_port (
        .sclk_i                      (sclk_i),
        .serial_chip_select_n_i      (serial_chip_select_n_i),
        .extended_control_enable_n_i (extended_control_enable_n_i),
        .sdi_i                       (sdi_i),
        .main_control_i              (main_control_reg),
        .first_fs_i                  (first_channel_full_scale_reg),
        .second_fs_i                 (second_channel_full_scale_reg),
        .wr_toggle_o                 (wr_toggle),
        .wr_addr_o                   (wr_addr),
        .wr_data_o                   (wr_data),
        .sdo_o                       (sdo_o),
        .sdo_oe_o                    (sdo_oe_o)
    );

    // Write toggle crosses into clk_i; the edge is taken after the second stage.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
        end else begin
            tog_s1_reg <= wr_toggle;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
        end
    end

    assign wr_event = tog_s2_reg ^ tog_s3_reg;

    // Register bank: written over the serial port, reset outside extended mode.
    always_comb begin
        main_control_next              = main_control_reg;
        first_channel_full_scale_next  = first_channel_full_scale_reg;
        second_channel_full_scale_next = second_channel_full_scale_reg;
        if (!extended_control_mode) begin
            main_control_next              = adc_ctrl_pkg::MAIN_CONTROL_RESET; // RQ12
            first_channel_full_scale_next  = adc_ctrl_pkg::FULL_SCALE_RESET;
            second_channel_full_scale_next = adc_ctrl_pkg::FULL_SCALE_RESET;
        end else if (wr_event) begin
            case (wr_addr)
                adc_ctrl_pkg::MAIN_CONTROL_ADDR: begin
                    main_control_next = wr_data;
                end
                adc_ctrl_pkg::FIRST_CHANNEL_FS_ADDR: begin
                    first_channel_full_scale_next = wr_data;
                end
                adc_ctrl_pkg::SECOND_CHANNEL_FS_ADDR: begin
                    second_channel_full_scale_next = wr_data;
                end
                default: begin
                    main_control_next = main_control_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            main_control_reg              <= adc_ctrl_pkg::MAIN_CONTROL_RESET;
            first_channel_full_scale_reg  <= adc_ctrl_pkg::FULL_SCALE_RESET;
            second_channel_full_scale_reg <= adc_ctrl_pkg::FULL_SCALE_RESET;
        end else begin
            main_control_reg              <= main_control_next;
            first_channel_full_scale_reg  <= first_channel_full_scale_next;
            second_channel_full_scale_reg <= second_channel_full_scale_next;
        end
    end

    // Effective settings: pins in pin mode, registers in extended mode, except that power-down pins still OR in and the demux pin always applies.
    always_comb begin
        mode_next = extended_control_mode;
        ndm_next  = ndm_pin; // RQ5
        if (extended_control_mode) begin
            off1_next = pd1_pin |
                main_control_reg[adc_ctrl_pkg::FIRST_CHANNEL_POWERDOWN_BIT_POS]; // RQ2
            off2_next = pd2_pin |
                main_control_reg[adc_ctrl_pkg::SECOND_CHANNEL_POWERDOWN_BIT_POS]; // RQ2
            tp_next   = main_control_reg[adc_ctrl_pkg::TEST_PATTERN_BIT_POS]; // RQ4
            phase_sel = main_control_reg[adc_ctrl_pkg::OUTPUT_PHASE_BIT_POS]; // RQ10
            fs1_next  = first_channel_full_scale_reg; // RQ7
            fs2_next  = second_channel_full_scale_reg; // RQ7
        end else begin
            off1_next = pd1_pin; // RQ1
            off2_next = pd2_pin; // RQ1
            tp_next   = tpm_pin; // RQ3
            phase_sel = ph_pin; // RQ8
            fs1_next  = fsr_pin ? adc_ctrl_pkg::FULL_SCALE_MID
                                : adc_ctrl_pkg::FULL_SCALE_MIN; // RQ6
            fs2_next  = fs1_next; // RQ6
        end
        ph90_next = phase_sel & ~ndm_pin; // RQ9
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mode_reg <= 1'b0;
            off1_reg <= 1'b0;
            off2_reg <= 1'b0;
            tp_reg   <= 1'b0;
            ndm_reg  <= 1'b0;
            ph90_reg <= 1'b0;
            fs1_reg  <= adc_ctrl_pkg::FULL_SCALE_MIN;
            fs2_reg  <= adc_ctrl_pkg::FULL_SCALE_MIN;
        end else begin
            mode_reg <= mode_next;
            off1_reg <= off1_next;
            off2_reg <= off2_next;
            tp_reg   <= tp_next;
            ndm_reg  <= ndm_next;
            ph90_reg <= ph90_next;
            fs1_reg  <= fs1_next;
            fs2_reg  <= fs2_next;
        end
    end

    assign off_vec = {off2_reg, off1_reg};

    // One power-up delay counter per channel.
    for (genvar ch = 0; ch < 2; ch++) begin : g_pu
        logic [CW-1:0] cnt_reg;
        logic [CW-1:0] cnt_next;
        logic          rdy_reg;
        logic          rdy_next;

        // Counter reloads while off; ready rises once it has run out.
        always_comb begin
            cnt_next = cnt_reg;
            rdy_next = 1'b0;
            if (off_vec[ch]) begin
                cnt_next = PU_LOAD; // RQ16
            end else if (cnt_reg != '0) begin
                cnt_next = cnt_reg - 1'b1;
            end else begin
                rdy_next = 1'b1; // RQ16
            end
        end

        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                cnt_reg <= PU_LOAD;
                rdy_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_next;
                rdy_reg <= rdy_next;
            end
        end

        assign ready_vec[ch] = rdy_reg;
    end

    assign extended_control_mode_o = mode_reg;
    assign first_channel_off_o     = off1_reg;
    assign second_channel_off_o    = off2_reg;
    assign first_channel_ready_o   = ready_vec[0];
    assign second_channel_ready_o  = ready_vec[1];
    assign test_pattern_o          = tp_reg;
    assign non_demuxed_o           = ndm_reg;
    assign phase_90_o              = ph90_reg;
    assign first_full_scale_o      = fs1_reg;
    assign second_full_scale_o     = fs2_reg;

endmodule

//--- verif/adc_ctrl_checker_properties.sv
// Concurrent checks bound to the top module.
// Assumes pins change only at clk_i edges.
`timescale 1ns/10ps
module adc_ctrl_checker #(
    parameter int POWERUP_CYCLES = 16
) (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        first_channel_powerdown_i,
    input wire logic        test_pattern_select_i,
    input wire logic        demux_ratio_select_i,
    input wire logic        input_range_select_i,
    input wire logic        output_phase_select_i,
    input wire logic        extended_control_enable_n_i,
    input wire logic        serial_chip_select_n_i,
    input wire logic        sdo_oe_o,
    input wire logic        extended_control_mode_o,
    input wire logic        first_channel_off_o,
    input wire logic        first_channel_ready_o,
    input wire logic        test_pattern_o,
    input wire logic        non_demuxed_o,
    input wire logic        phase_90_o,
    input wire logic [15:0] first_full_scale_o,
    input wire logic [15:0] second_full_scale_o
);
    localparam int RDY_MIN = POWERUP_CYCLES;
    localparam int RDY_MAX = POWERUP_CYCLES + 3;
    logic [2:0] settle_reg;
    logic [2:0] settle_next;
    logic       settled;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // Waits for the pin pipeline to fill after reset.
    always_comb begin
        settle_next = settle_reg + {2'h0, settle_reg != 3'h7};
    end
    always_ff @(posedge clk_i) begin
        settle_reg <= sys_rst_i ? 3'h0 : settle_next;
    end
    assign settled = settle_reg == 3'h7;

    AST_EXT_MODE: assert property (
        settled |-> extended_control_mode_o
            == !$past(extended_control_enable_n_i, 3))
        else $error("mode vs enable");
    AST_FIRST_PD: assert property (
        settled && $past(first_channel_powerdown_i, 3)
            |-> first_channel_off_o)
        else $error("pd pin ignored");
    AST_DEMUX: assert property (
        settled |-> non_demuxed_o == $past(demux_ratio_select_i, 3))
        else $error("demux vs pin");
    AST_PHASE_GATE: assert property (
        phase_90_o |-> !non_demuxed_o)
        else $error("phase in 1:1");
    AST_PIN_TP: assert property (
        settled ##0 (!extended_control_mode_o) [*3]
            |-> test_pattern_o == $past(test_pattern_select_i, 3))
        else $error("pattern vs pin");
    AST_PIN_RANGE: assert property (
        settled ##0 (!extended_control_mode_o) [*3]
            |-> second_full_scale_o == first_full_scale_o
            && first_full_scale_o == ($past(input_range_select_i, 3)
            ? adc_ctrl_pkg::FULL_SCALE_MID : adc_ctrl_pkg::FULL_SCALE_MIN))
        else $error("range vs pin");
    AST_PIN_PHASE: assert property (
        settled ##0 (!extended_control_mode_o) [*3] |-> phase_90_o
            == ($past(output_phase_select_i, 3) && !non_demuxed_o))
        else $error("phase vs pin");
    AST_SDO_RELEASE: assert property (
        serial_chip_select_n_i || extended_control_enable_n_i
            |-> !sdo_oe_o)
        else $error("sdo driven idle");
    AST_OFF_NOT_READY: assert property (
        first_channel_off_o && $past(first_channel_off_o)
            |-> !first_channel_ready_o)
        else $error("ready while off");
    AST_READY_DELAY: assert property (
        $fell(first_channel_off_o) |-> !first_channel_ready_o
            ##[RDY_MIN:RDY_MAX] first_channel_ready_o)
        else $error("ready late");
endmodule

bind adc_control_pin_register_select adc_ctrl_checker #(
    .POWERUP_CYCLES(POWERUP_CYCLES)
) u_checker (.*);

//--- verif/serial_host_model.sv
// Serial master model sending 24-bit frames.
// Assumes rise sampling and fall driving in the device.
`timescale 1ns/10ps
module serial_host_model (
    output logic      sclk_o,
    output logic      serial_chip_select_n_o,
    output logic      sdi_o,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i
);
    // Idle: clock low, deselected.
    initial begin
        sclk_o = 1'b0;
        serial_chip_select_n_o = 1'b1;
        sdi_o = 1'b0;
    end

    // One frame at a 6 ns clock; undriven read bits are unknown.
    task automatic frame(input logic rd, input logic [3:0] addr,
                         input logic [15:0] wdata,
                         output logic [15:0] rdata);
        logic [23:0] word;
        word = {rd, 3'h0, addr, wdata};
        rdata = 16'h0000;
        serial_chip_select_n_o = 1'b0;
        for (int k = 0; k < 24; k++) begin
            sdi_o = word[23 - k];
            #3;
            sclk_o = 1'b1;
            if (k >= 8) rdata[23 - k] = sdo_oe_i ? sdo_i : 1'bx;
            #3;
            sclk_o = 1'b0;
        end
        #3;
        serial_chip_select_n_o = 1'b1;
        sdi_o = ~sdi_o; // Released line shows the inverse.
    endtask
endmodule

//--- verif/adc_control_pin_register_select_tb.sv
// Self-checking bench of the control selection block.
// Assumes the checker binds itself.
`timescale 1ns/10ps
module adc_control_pin_register_select_tb;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, pd1 = 1'b0, pd2 = 1'b0;
    logic tp = 1'b0, dmx = 1'b0, rng = 1'b0, ph = 1'b0, en_n = 1'b1;
    logic sclk, cs_n, sdi, sdo_o, sdo_oe_o, mode, off1, off2, rdy1, rdy2;
    logic pat, demux_ratio_select, ph90;
    logic [15:0] fs1, fs2;
    int error_cnt = 0, samples_checked = 0;

    adc_control_pin_register_select #(.POWERUP_CYCLES(2)) dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk),
        .first_channel_powerdown_i(pd1), .second_channel_powerdown_i(pd2),
        .test_pattern_select_i(tp), .demux_ratio_select_i(dmx),
        .input_range_select_i(rng), .output_phase_select_i(ph),
        .extended_control_enable_n_i(en_n), .serial_chip_select_n_i(cs_n),
        .sdi_i(sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
        .extended_control_mode_o(mode), .first_channel_off_o(off1),
        .second_channel_off_o(off2), .first_channel_ready_o(rdy1),
        .second_channel_ready_o(rdy2), .test_pattern_o(pat),
        .non_demuxed_o(demux_ratio_select), .phase_90_o(ph90),
        .first_full_scale_o(fs1), .second_full_scale_o(fs2));
    serial_host_model host (.sclk_o(sclk), .serial_chip_select_n_o(cs_n),
        .sdi_o(sdi), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o));

    // System clock at 25 MHz.
    always #20 clk_i = ~clk_i;

    task automatic check(input string name, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic chk1(input string name, input logic seen, exp);
        check(name, {15'h0, seen}, {15'h0, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] v;
        host.frame(1'b0, a, d, v);
        tick(8);
    endtask
    task automatic rd_chk(input string name, input logic [3:0] a,
                          input logic [15:0] exp);
        logic [15:0] v;
        host.frame(1'b1, a, 16'h0000, v);
        #1;
        check(name, v, exp);
        chk1("sdo off", sdo_oe_o, 1'b0);
    endtask

    task automatic test_pins();
        logic [3:0] c;
        logic [15:0] fs;
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            @(posedge clk_i);
            {tp, dmx, rng, ph} <= c;
            tick(5);
            fs = c[1] ? adc_ctrl_pkg::FULL_SCALE_MID
                      : adc_ctrl_pkg::FULL_SCALE_MIN;
            chk1("mode", mode, 1'b0);
            chk1("pattern", pat, c[3]);
            chk1("demux", demux_ratio_select, c[2]);
            check("fs1", fs1, fs);
            check("fs2", fs2, fs);
            chk1("phase", ph90, c[0] & ~c[2]);
        end
        $display("test pins done");
    endtask

    task automatic test_powerdown();
        @(posedge clk_i);
        pd1 <= 1'b1;
        tick(5);
        chk1("off1", off1, 1'b1);
        chk1("off2", off2, 1'b0);
        chk1("rdy1", rdy1, 1'b0);
        @(posedge clk_i);
        pd1 <= 1'b0;
        tick(4);
        chk1("rdy1 early", rdy1, 1'b0);
        tick(4);
        chk1("rdy1 late", rdy1, 1'b1);
        chk1("rdy2", rdy2, 1'b1);
        $display("test powerdown done");
    endtask

    task automatic test_ext();
        @(posedge clk_i);
        {en_n, tp, ph, dmx, rng} <= 5'b01100;
        tick(6);
        chk1("mode", mode, 1'b1);
        chk1("pattern", pat, 1'b0);
        chk1("phase", ph90, 1'b0);
        check("fs1", fs1, adc_ctrl_pkg::FULL_SCALE_RESET);
        wr(adc_ctrl_pkg::MAIN_CONTROL_ADDR, 16'h5800); // Bits 14, 12, 11.
        chk1("pattern", pat, 1'b1);
        chk1("off1", off1, 1'b1);
        chk1("off2", off2, 1'b0);
        chk1("phase", ph90, 1'b1);
        @(posedge clk_i);
        {dmx, pd2} <= 2'b11;
        tick(5);
        chk1("phase", ph90, 1'b0);
        chk1("off2", off2, 1'b1);
        @(posedge clk_i);
        {dmx, pd2, tp, ph, rng} <= 5'b00001;
        tick(5);
        chk1("pattern", pat, 1'b1);
        chk1("phase", ph90, 1'b1);
        check("fs1", fs1, adc_ctrl_pkg::FULL_SCALE_RESET);
        wr(adc_ctrl_pkg::FIRST_CHANNEL_FS_ADDR, 16'h1234);
        wr(adc_ctrl_pkg::SECOND_CHANNEL_FS_ADDR, 16'habcd);
        check("fs1", fs1, 16'h1234);
        check("fs2", fs2, 16'habcd);
        rd_chk("main", adc_ctrl_pkg::MAIN_CONTROL_ADDR, 16'h5800);
        rd_chk("fs1", adc_ctrl_pkg::FIRST_CHANNEL_FS_ADDR, 16'h1234);
        wr(4'h5, 16'hffff);
        rd_chk("unmapped", 4'h5, 16'h0000);
        rd_chk("fs2", adc_ctrl_pkg::SECOND_CHANNEL_FS_ADDR, 16'habcd);
        $display("test extended done");
    endtask

    task automatic test_disable();
        @(posedge clk_i);
        en_n <= 1'b1;
        tick(5);
        chk1("mode", mode, 1'b0);
        check("fs1", fs1, adc_ctrl_pkg::FULL_SCALE_MID);
        wr(adc_ctrl_pkg::MAIN_CONTROL_ADDR, 16'h1000);
        @(posedge clk_i);
        en_n <= 1'b0;
        tick(6);
        chk1("off1", off1, 1'b0);
        chk1("pattern", pat, 1'b0);
        rd_chk("main", adc_ctrl_pkg::MAIN_CONTROL_ADDR, 16'h0000);
        rd_chk("fs1", adc_ctrl_pkg::FIRST_CHANNEL_FS_ADDR,
               adc_ctrl_pkg::FULL_SCALE_RESET);
        $display("test disable done");
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Reset for three cycles, then each scenario.
    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        tick(12);
        test_pins();
        test_powerdown();
        test_ext();
        test_disable();
        print_verdict();
    end

    // Watchdog: 5000 cycles, far past the run.
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
endmodule
